// file: design/laf_pkg.sv
// Package: register map, field layout and reset values of the alert/flag logic
package laf_pkg;

	// Register pointer values
	localparam logic [7:0] PTR_CONFIG  = 8'h00;
	localparam logic [7:0] PTR_SHUNT   = 8'h01;
	localparam logic [7:0] PTR_BUS     = 8'h02;
	localparam logic [7:0] PTR_POWER   = 8'h03;
	localparam logic [7:0] PTR_CURRENT = 8'h04;
	localparam logic [7:0] PTR_MASK    = 8'h06;
	localparam logic [7:0] PTR_LIMIT   = 8'h07;

	// alert_mask_enable field positions
	localparam int EN_MSB     = 15;
	localparam int EN_LSB     = 10;
	localparam int FUNC_FLAG_BIT = 4;
	localparam int DONE_FLAG_BIT = 3;
	localparam int OVERFLOW_BIT  = 2;
	localparam int INVERT_BIT = 1;
	localparam int LATCH_BIT  = 0;

	// Index into the six stored enable bits (bit 10 is index 0)
	localparam int EN_READY       = 0;
	localparam int EN_PWR_OVER    = 1;
	localparam int EN_BUS_UNDER   = 2;
	localparam int EN_BUS_OVER    = 3;
	localparam int EN_SHUNT_UNDER = 4;
	localparam int EN_SHUNT_OVER  = 5;

	// Operating mode field of the configuration word
	localparam int             MODE_MSB  = 2;
	localparam int             MODE_LSB  = 0;
	localparam logic [2:0]     MODE_PD_A = 3'h0;
	localparam logic [2:0]     MODE_PD_B = 3'h4;

	// Reset values
	localparam logic [5:0]  EN_RST    = 6'h00;
	localparam logic [15:0] LIMIT_RST = 16'h0000;
	localparam logic [15:0] WORD_ZERO = 16'h0000;

	typedef struct packed {
		logic [5:0]  en;
		logic        invert;
		logic        latch;
		logic        func_flag;
		logic        done_flag;
		logic        overflow_flag;
		logic [15:0] limit;
		logic [15:0] rdata;
		logic        drive;
	} laf_state_t;

endpackage : laf_pkg

// file: design/laf_cmp_if.sv
// Interface: carries the compare selection, operands and result between top and comparator
`timescale 1ns/10ps
interface laf_cmp_if;
	logic [4:0]  fn_en;
	logic [15:0] limit;
	logic [15:0] shunt;
	logic [15:0] bus;
	logic [15:0] power;
	logic        violation;

	modport ctl (output fn_en, output limit, output shunt, output bus, output power, input violation);
	modport cmp (input fn_en, input limit, input shunt, input bus, input power, output violation);
endinterface : laf_cmp_if

// file: design/laf_compare.sv
// Limit comparator: priority select of one compare function against the threshold
`timescale 1ns/10ps
module laf_compare
(
	// Compare operands and result
	laf_cmp_if.cmp cif
);

	// fn_en[4]..fn_en[0] = shunt over, shunt under, bus over, bus under, power over
	always_comb
	begin
		if (cif.fn_en[4])
			cif.violation = $signed(cif.shunt) > $signed(cif.limit);
		else if (cif.fn_en[3])
			cif.violation = $signed(cif.shunt) < $signed(cif.limit);
		else if (cif.fn_en[2])
			cif.violation = cif.bus > cif.limit;
		else if (cif.fn_en[1])
			cif.violation = cif.bus < cif.limit;
		else if (cif.fn_en[0])
			cif.violation = cif.power > cif.limit;
		else
			cif.violation = 1'b0;
	end

endmodule : laf_compare

// file: design/laf_top.sv
// Top: alert pin, alert/conversion/overflow flags and pointer-addressed registers
//
// Overview of operation
// - With power over-limit enabled, alert when power result exceeds the threshold.
// - With conversion-ready alert enabled, alert when the conversion done flag sets.
// - Only one compare function drives alert; conversion ready may also drive it.
// - Alert function flag shows the compare function caused the alert.
// - Latch mode: alert function flag holds until mask/enable is read.
// - Transparent mode: flag clears after next conversion without alert condition.
// - Conversion done flag sets only when the full measurement cycle finishes.
// - Configuration write clears conversion done, unless mode is power-down.
// - Reading mask/enable clears conversion done flag.
// - Latest conversion results stay readable at any time.
// - Math overflow flag sets on arithmetic overflow of current/power.
// - Sense invert bit: one gives active-high alert, zero active-low; resets zero.
// - Latch bit selects latching for alert output and flags, else transparent.
// - Sixteen-bit threshold compared with the register the enabled function selects.
// - Bits 15 to 12 enable shunt over, shunt under, bus over, bus under.
// - Among bits 15 to 11 only the highest set enable is honoured.
`timescale 1ns/10ps
module laf_top
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// Register access from the serial engine
	input  wire logic [7:0]  reg_ptr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	// Measurement datapath
	input  wire logic [15:0] shunt_val,
	input  wire logic [15:0] bus_val,
	input  wire logic [15:0] power_val,
	input  wire logic [15:0] current_val,
	input  wire logic        conv_cycle_done,
	input  wire logic        math_overflow,
	// Open-drain alert pin
	output logic             alert_o,
	output logic             alert_oe_n
);

	////////////////////////////////////////////////////////////////////////////////
	laf_pkg::laf_state_t st_ff;
	laf_pkg::laf_state_t nxt_st;
	laf_cmp_if           cif ();
	logic                mask_rd;
	logic                mask_wr;
	logic                limit_wr;
	logic                cfg_clr;
	logic                alert_act;
	logic [15:0]         rd_mux;

	assign cif.fn_en = st_ff.en[laf_pkg::EN_SHUNT_OVER:laf_pkg::EN_PWR_OVER];
	assign cif.limit = st_ff.limit;
	assign cif.shunt = shunt_val;
	assign cif.bus   = bus_val;
	assign cif.power = power_val;

	laf_compare u_cmp
	(
		.cif (cif.cmp)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read data selection
	always_comb
	begin
		case (reg_ptr)
			laf_pkg::PTR_SHUNT:   rd_mux = shunt_val;
			laf_pkg::PTR_BUS:     rd_mux = bus_val;
			laf_pkg::PTR_POWER:   rd_mux = power_val;
			laf_pkg::PTR_CURRENT: rd_mux = current_val;
			laf_pkg::PTR_LIMIT:   rd_mux = st_ff.limit;
			laf_pkg::PTR_MASK:
			begin
				rd_mux                                     = laf_pkg::WORD_ZERO;
				rd_mux[laf_pkg::EN_MSB:laf_pkg::EN_LSB]    = st_ff.en;
				rd_mux[laf_pkg::FUNC_FLAG_BIT]             = st_ff.func_flag;
				rd_mux[laf_pkg::DONE_FLAG_BIT]             = st_ff.done_flag;
				rd_mux[laf_pkg::OVERFLOW_BIT]              = st_ff.overflow_flag;
				rd_mux[laf_pkg::INVERT_BIT]                = st_ff.invert;
				rd_mux[laf_pkg::LATCH_BIT]                 = st_ff.latch;
			end
			// Configuration lives in the datapath block; reads zero here
			default:              rd_mux = laf_pkg::WORD_ZERO;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb
	begin
		nxt_st   = st_ff;
		mask_rd  = reg_rd && (reg_ptr == laf_pkg::PTR_MASK);
		mask_wr  = reg_wr && (reg_ptr == laf_pkg::PTR_MASK);
		limit_wr = reg_wr && (reg_ptr == laf_pkg::PTR_LIMIT);
		cfg_clr  = reg_wr && (reg_ptr == laf_pkg::PTR_CONFIG)
			&& (reg_wdata[laf_pkg::MODE_MSB:laf_pkg::MODE_LSB] != laf_pkg::MODE_PD_A)
			&& (reg_wdata[laf_pkg::MODE_MSB:laf_pkg::MODE_LSB] != laf_pkg::MODE_PD_B);

		if (mask_wr)
		begin
			nxt_st.en     = reg_wdata[laf_pkg::EN_MSB:laf_pkg::EN_LSB];
			nxt_st.invert = reg_wdata[laf_pkg::INVERT_BIT];
			nxt_st.latch  = reg_wdata[laf_pkg::LATCH_BIT];
		end
		if (limit_wr)
			nxt_st.limit = reg_wdata;
		if (reg_rd)
			nxt_st.rdata = rd_mux;

		// Conversion done: set beats any clear in the same cycle
		if (mask_rd || cfg_clr)
			nxt_st.done_flag = 1'b0;
		if (conv_cycle_done)
			nxt_st.done_flag = 1'b1;

		// Compare result is judged once per finished conversion
		if (st_ff.latch)
		begin
			if (mask_rd)
				nxt_st.func_flag = 1'b0;
		end
		else if (conv_cycle_done && !cif.violation)
			nxt_st.func_flag = 1'b0;
		if (conv_cycle_done && cif.violation)
			nxt_st.func_flag = 1'b1;

		// Overflow follows the same latch/transparent split as the alert flag
		if (st_ff.latch)
		begin
			if (mask_rd)
				nxt_st.overflow_flag = 1'b0;
		end
		else if (conv_cycle_done && !math_overflow)
			nxt_st.overflow_flag = 1'b0;
		if (math_overflow)
			nxt_st.overflow_flag = 1'b1;

		// Latched alert follows the function flag, which holds until the mask read
		alert_act    = st_ff.func_flag || (st_ff.en[laf_pkg::EN_READY] && st_ff.done_flag);
		nxt_st.drive = alert_act ^ st_ff.invert;
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff.en     <= laf_pkg::EN_RST;
			st_ff.invert <= 1'b0;
			st_ff.latch  <= 1'b0;
			st_ff.func_flag     <= 1'b0;
			st_ff.done_flag     <= 1'b0;
			st_ff.overflow_flag <= 1'b0;
			st_ff.limit  <= laf_pkg::LIMIT_RST;
			st_ff.rdata  <= laf_pkg::WORD_ZERO;
			// Normal polarity, inactive: pin released
			st_ff.drive  <= 1'b0;
		end
		else
			st_ff <= nxt_st;
	end

	// Pin only ever pulls low; release lets the pull-up win
	assign alert_o    = 1'b0;
	assign alert_oe_n = !st_ff.drive;
	assign reg_rdata  = st_ff.rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	done_set_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		conv_cycle_done |=> st_ff.done_flag)
		else $error("conversion done flag not set after cycle end");

	mask_rd_clr_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_rd && reg_ptr == laf_pkg::PTR_MASK && !conv_cycle_done) |=> !st_ff.done_flag)
		else $error("mask read did not clear conversion done");

	cfg_wr_clr_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(cfg_clr && !conv_cycle_done) |=> !st_ff.done_flag)
		else $error("configuration write did not clear conversion done");

	flag_latch_hold_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.latch && st_ff.func_flag && !mask_rd) |=> st_ff.func_flag)
		else $error("latched alert flag dropped without mask read");

	flag_transp_clr_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(!st_ff.latch && conv_cycle_done && !cif.violation) |=> !st_ff.func_flag)
		else $error("transparent alert flag not cleared");

	power_over_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.en[laf_pkg::EN_SHUNT_OVER:laf_pkg::EN_BUS_UNDER] == 4'h0 && st_ff.en[laf_pkg::EN_PWR_OVER]
			&& conv_cycle_done && power_val > st_ff.limit) |=> st_ff.func_flag)
		else $error("power over threshold did not flag");

	shunt_prio_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.en[laf_pkg::EN_SHUNT_OVER] && conv_cycle_done
			&& $signed(shunt_val) > $signed(st_ff.limit)) |=> st_ff.func_flag)
		else $error("highest compare enable not honoured");

	pin_sense_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> alert_oe_n == !($past(alert_act) ^ $past(st_ff.invert)))
		else $error("alert pin sense wrong");

	latch_pin_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.latch && st_ff.func_flag && !mask_rd) |=> ##1 alert_oe_n == $past(st_ff.invert))
		else $error("latched alert pin released early");

	ready_pin_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(st_ff.en[laf_pkg::EN_READY] && st_ff.done_flag) |=> alert_oe_n == $past(st_ff.invert))
		else $error("conversion ready did not assert alert");

	overflow_set_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		math_overflow |=> st_ff.overflow_flag)
		else $error("overflow flag not set");

	result_read_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_rd && reg_ptr == laf_pkg::PTR_POWER) |=> reg_rdata == $past(power_val))
		else $error("power result read mismatch");

	flag_visible_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_rd && reg_ptr == laf_pkg::PTR_MASK) |=> reg_rdata[laf_pkg::FUNC_FLAG_BIT] == $past(st_ff.func_flag))
		else $error("alert function flag not visible on read");

	limit_wr_a: assert property (
		@(posedge sys_clk) disable iff (!rst_n)
		(reg_wr && reg_ptr == laf_pkg::PTR_LIMIT) |=> st_ff.limit == $past(reg_wdata))
		else $error("threshold write lost");

endmodule : laf_top

// file: verif/laf_host_model.sv
// Host controller model issuing word accesses on the register port
`timescale 1ns/10ps
module laf_host_model
(
	// Clock
	input  wire logic        sys_clk,
	// Register port
	output logic      [7:0]  reg_ptr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata
);
	initial
	begin
		reg_ptr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 16'h0000;
	end
	task automatic wr(input logic [7:0] p, input logic [15:0] d);
		@(posedge sys_clk);
		reg_ptr <= p;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		// Released data must not keep showing the written word
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [7:0] p, output logic [15:0] d);
		@(posedge sys_clk);
		reg_ptr <= p;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : laf_host_model

// file: verif/tb.sv
// Self-checking testbench of the alert and flag logic
`timescale 1ns/10ps
module tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_ptr;
	logic reg_wr, reg_rd, conv_cycle_done = 1'b0, math_overflow = 1'b0, alert_o, alert_oe_n;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic [15:0] shunt_val = 16'h0000, bus_val = 16'h0000, power_val = 16'h0000, current_val = 16'h0000;
	int err_total = 0;
	int comparisons = 0;
	always #20 sys_clk = ~sys_clk;
	laf_host_model host_u (.sys_clk(sys_clk), .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	laf_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_ptr(reg_ptr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .shunt_val(shunt_val), .bus_val(bus_val),
		.power_val(power_val), .current_val(current_val), .conv_cycle_done(conv_cycle_done),
		.math_overflow(math_overflow), .alert_o(alert_o), .alert_oe_n(alert_oe_n));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic pin(input logic exp);
		chk("alert_oe_n", {15'h0000, alert_oe_n}, {15'h0000, exp});
	endtask : pin
	task automatic mask(input logic [15:0] exp);
		host_u.rd(laf_pkg::PTR_MASK, v);
		chk("mask word", v, exp);
	endtask : mask
	// Pin follows the flags one edge later, so wait for it
	task automatic settle();
		@(posedge sys_clk);
		#1;
	endtask : settle
	task automatic meas(input logic [15:0] s, input logic [15:0] b, input logic [15:0] p, input logic o);
		@(posedge sys_clk);
		shunt_val <= s;
		bus_val <= b;
		power_val <= p;
		conv_cycle_done <= 1'b1;
		math_overflow <= o;
		@(posedge sys_clk);
		conv_cycle_done <= 1'b0;
		math_overflow <= 1'b0;
		settle();
	endtask : meas
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		pin(1'b1);
		chk("alert_o", {15'h0000, alert_o}, 16'h0000);
		mask(16'h0000);
		host_u.rd(laf_pkg::PTR_LIMIT, v);
		chk("threshold", v, 16'h0000);
		$display("test reset done");
	endtask : t_reset
	task automatic t_power();
		host_u.wr(laf_pkg::PTR_LIMIT, 16'h0100);
		host_u.wr(laf_pkg::PTR_MASK, 16'h0800);
		meas(16'h0000, 16'h0000, 16'h0200, 1'b0);
		pin(1'b0);
		mask(16'h0818);
		settle();
		pin(1'b0);
		meas(16'h0000, 16'h0000, 16'h0050, 1'b0);
		pin(1'b1);
		host_u.rd(laf_pkg::PTR_POWER, v);
		chk("power", v, 16'h0050);
		$display("test power done");
	endtask : t_power
	task automatic t_latch();
		host_u.wr(laf_pkg::PTR_MASK, 16'hA001);
		// Negative shunt is not over; bus over is lower priority
		meas(16'h8300, 16'h0200, 16'h0000, 1'b0);
		pin(1'b1);
		meas(16'h0200, 16'h0000, 16'h0000, 1'b0);
		pin(1'b0);
		meas(16'h0000, 16'h0000, 16'h0000, 1'b0);
		pin(1'b0);
		mask(16'hA019);
		settle();
		pin(1'b1);
		mask(16'hA001);
		$display("test latch done");
	endtask : t_latch
	task automatic t_ready();
		host_u.wr(laf_pkg::PTR_MASK, 16'h0402);
		settle();
		pin(1'b0);
		meas(16'h0000, 16'h0000, 16'h0000, 1'b0);
		pin(1'b1);
		host_u.wr(laf_pkg::PTR_CONFIG, 16'h0007);
		settle();
		pin(1'b0);
		meas(16'h0000, 16'h0000, 16'h0000, 1'b0);
		host_u.wr(laf_pkg::PTR_CONFIG, 16'h0004);
		settle();
		pin(1'b1);
		mask(16'h040A);
		settle();
		pin(1'b0);
		$display("test ready done");
	endtask : t_ready
	task automatic t_misc();
		meas(16'h0000, 16'h0000, 16'h0000, 1'b1);
		mask(16'h040E);
		@(posedge sys_clk);
		current_val <= 16'h1234;
		host_u.rd(laf_pkg::PTR_CURRENT, v);
		chk("current", v, 16'h1234);
		host_u.rd(8'h05, v);
		chk("unmapped", v, 16'h0000);
		host_u.wr(laf_pkg::PTR_MASK, 16'hFFFF);
		mask(16'hFC07);
		mask(16'hFC03);
		$display("test misc done");
	endtask : t_misc
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		settle();
		t_reset();
		t_power();
		t_latch();
		t_ready();
		t_misc();
		report_and_stop();
	end
	initial
	begin
		#(40 * 3000);
		err_total++;
		report_and_stop();
	end
endmodule : tb
